// [rtl/cmp_pwm_timer.sv]
// comparator control and 8-bit pwm timer behind an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "cmp_pwm_defines.svh"

// Functional notes
// RQ1: minus input from six sources, control bits 3:1
// RQ2: plus input pin or ladder, bit 0
// RQ3: control bit 4 inverts comparator result
// RQ4: result to pin directly or tick sampled
// RQ5: comparator result can request an interrupt
// RQ6: ladder range bits 5:4, tap bits 3:0
// RQ7: control bit 7 enables the comparator
// RQ8: pin routing bit lives in reference select
// RQ9: software disables digital input on analog pins
// RQ10: timer clock source from control bits 7:4
// RQ11: timer output to pin per bits 3:2
// RQ12: prescaler divides by 1, 4, 16, 64
// RQ13: scaler divides further, giving the tick
// RQ14: 8-bit up counter, software readable and writable
// RQ15: counter clears when reaching the bound
// RQ16: period mode and 6/8-bit pwm mode
// RQ17: control bit 1 pwm, scaler bit 7 six-bit
// RQ18: period mode toggles output at each wrap
// RQ19: pwm period 256 or 64 ticks
// RQ20: pwm high while count at or below bound
// RQ21: result sampled per tick, readable status bit
module cmp_pwm_timer
    import cmp_pwm_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int SCL_W  = 5
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic [31:0]            o_prdata,
    input  wire logic              i_comp_raw,
    input  wire logic              i_fast_rc_osc,
    input  wire logic              i_slow_rc_osc,
    input  wire logic              i_port_a_bit0,
    input  wire logic              i_port_a_bit4,
    output logic                   o_comp_enable,
    output logic [5:0]             o_minus_route,
    output logic                   o_plus_port_a_bit4,
    output logic                   o_plus_ladder,
    output logic [1:0]             o_ladder_range,
    output logic [3:0]             o_ladder_tap,
    output logic                   o_comp_irq_req,
    output logic                   o_timer_irq_req,
    output logic                   o_port_a_bit0_out,
    output logic                   o_port_a_bit0_oe,
    output logic                   o_port_a_bit3_out,
    output logic                   o_port_a_bit3_oe,
    output logic                   o_port_a_bit4_out,
    output logic                   o_port_a_bit4_oe
);

    ////////////////////////////////////////////////////////////////////////
    // address decode shared by the read and write paths
    function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] addr);
        case (addr)
            `OFF_CMP_CTRL:   reg_index = 4'h8;
            `OFF_REF_SEL:    reg_index = 4'h9;
            `OFF_TMR_CTRL:   reg_index = 4'hA;
            `OFF_TMR_SCALER: reg_index = 4'hB;
            `OFF_TMR_COUNT:  reg_index = 4'hC;
            `OFF_TMR_BOUND:  reg_index = 4'hD;
            default:         reg_index = 4'h0;
        endcase
    endfunction : reg_index

    logic [7:0]  cc_r;
    logic [7:0]  cc_nxt;
    logic [7:0]  rs_r;
    logic [7:0]  rs_nxt;
    logic [7:0]  tc_r;
    logic [7:0]  tc_nxt;
    logic [7:0]  ts_r;
    logic [7:0]  ts_nxt;
    logic [7:0]  bound_r;
    logic [7:0]  bound_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic [3:0]  wr_idx;
    logic [3:0]  rd_idx;
    logic        access;
    logic        wr_en;
    logic        cnt_wr;
    logic        bound_wr;

    logic [7:0]  cnt_r;
    logic [7:0]  cnt_nxt;
    logic        tmr_out_r;
    logic        tmr_out_nxt;
    logic [3:0]  src_prev_r;
    logic [3:0]  src_now;
    logic [3:0]  src_rise;
    logic        step;
    logic        tick;
    logic        pwm_mode;
    logic [7:0]  cnt_top;
    logic        cnt_wrap;
    logic        irq_nxt;
    logic        timer_irq_r;

    logic        comp_val;
    logic        comp_prev_r;
    logic        comp_samp_r;
    logic        comp_samp_nxt;
    logic        comp_irq_r;
    logic        pa0_out_r;
    logic        pa0_out_nxt;
    tm_src_t     src_sel;
    out_sel_t    out_sel;
    minus_sel_t  minus_sel;

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, error on unmapped addresses
    assign access    = i_psel & i_penable;
    assign wr_idx    = reg_index(i_paddr);
    assign rd_idx    = reg_index(i_paddr);
    assign wr_en     = access & i_pwrite & (wr_idx != 4'h0);
    assign cnt_wr    = wr_en & (wr_idx == 4'hC);
    assign bound_wr  = wr_en & (wr_idx == 4'hD);
    assign o_pready  = 1'b1;
    assign o_pslverr = access & (wr_idx == 4'h0);
    assign o_prdata  = prdata_r;

    // read data is captured in the setup cycle so it stands in the access cycle
    always_comb begin
        prdata_nxt = prdata_r;
        if (i_psel && !i_penable) begin
            case (rd_idx)
                4'h8:    prdata_nxt = {24'h000000, cc_r[7], comp_val, cc_r[5:0]}; // RQ21
                4'h9:    prdata_nxt = {24'h000000, rs_r};
                4'hA:    prdata_nxt = {24'h000000, tc_r};
                4'hB:    prdata_nxt = {24'h000000, ts_r};
                4'hC:    prdata_nxt = {24'h000000, cnt_r}; // RQ14
                4'hD:    prdata_nxt = {24'h000000, bound_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    // register writes; the result bit of comparator_control is read only
    always_comb begin
        cc_nxt    = cc_r;
        rs_nxt    = rs_r;
        tc_nxt    = tc_r;
        ts_nxt    = ts_r;
        bound_nxt = bound_r;
        if (wr_en) begin
            case (wr_idx)
                4'h8:    cc_nxt = {i_pwdata[7], 1'b0, i_pwdata[5:0]};
                4'h9:    rs_nxt = i_pwdata[7:0];
                4'hA:    tc_nxt = i_pwdata[7:0];
                4'hB:    ts_nxt = i_pwdata[7:0];
                4'hD:    bound_nxt = i_pwdata[7:0];
                default: cc_nxt = cc_r;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cc_r     <= `REG_RST;
            rs_r     <= `REG_RST;
            tc_r     <= `REG_RST;
            ts_r     <= `REG_RST;
            bound_r  <= `REG_RST;
            prdata_r <= 32'h00000000;
        end else begin
            cc_r     <= cc_nxt;
            rs_r     <= rs_nxt;
            tc_r     <= tc_nxt;
            ts_r     <= ts_nxt;
            bound_r  <= bound_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // comparator input routing and ladder taps
    assign minus_sel          = minus_sel_t'(cc_r[`CC_MINUS_HI:`CC_MINUS_LO]);
    assign o_comp_enable      = cc_r[`CC_EN]; // RQ7
    assign o_plus_port_a_bit4 = cc_r[`CC_PLUS]; // RQ2
    assign o_plus_ladder      = ~cc_r[`CC_PLUS]; // RQ2
    assign o_ladder_range     = rs_r[`RS_RANGE_HI:`RS_RANGE_LO]; // RQ6
    assign o_ladder_tap       = rs_r[`RS_TAP_HI:`RS_TAP_LO]; // RQ6

    // one-hot switch enables; unused codes open every switch
    always_comb begin
        o_minus_route = 6'h00;
        case (minus_sel)
            MIN_PA3:  o_minus_route = 6'h01; // RQ1
            MIN_PA4:  o_minus_route = 6'h02;
            MIN_BGAP: o_minus_route = 6'h04;
            MIN_LADR: o_minus_route = 6'h08;
            MIN_PA6:  o_minus_route = 6'h10;
            MIN_PA7:  o_minus_route = 6'h20;
            default:  o_minus_route = 6'h00;
        endcase
    end

    // a disabled comparator reads as zero so it cannot fake an edge
    assign comp_val = cc_r[`CC_EN] & (i_comp_raw ^ cc_r[`CC_INVERT]); // RQ3

    // tick sampling, pin drive and edge request
    always_comb begin
        comp_samp_nxt = tick ? comp_val : comp_samp_r; // RQ21
        pa0_out_nxt   = cc_r[`CC_SAMPLED] ? comp_samp_r : comp_val; // RQ4
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            comp_prev_r <= 1'b0;
            comp_samp_r <= 1'b0;
            comp_irq_r  <= 1'b0;
            pa0_out_r   <= 1'b0;
        end else begin
            comp_prev_r <= comp_val;
            comp_samp_r <= comp_samp_nxt;
            comp_irq_r  <= comp_val & ~comp_prev_r; // RQ5
            pa0_out_r   <= pa0_out_nxt;
        end
    end

    assign o_comp_irq_req    = comp_irq_r;
    assign o_port_a_bit0_out = pa0_out_r;
    assign o_port_a_bit0_oe  = rs_r[`RS_PIN_OUT] & cc_r[`CC_EN]; // RQ8

    ////////////////////////////////////////////////////////////////////////
    // timer source: inputs are synchronous, so one flop finds each rise
    assign src_sel = tm_src_t'(tc_r[`TC_SRC_HI:`TC_SRC_LO]);
    assign src_now = {i_port_a_bit4, i_port_a_bit0, i_slow_rc_osc, i_fast_rc_osc};
    assign src_rise = src_now & ~src_prev_r;

    always_comb begin
        case (src_sel)
            SRC_SYS:  step = 1'b1; // RQ10
            SRC_FAST: step = src_rise[0];
            SRC_SLOW: step = src_rise[1];
            SRC_PA0:  step = src_rise[2];
            SRC_PA4:  step = src_rise[3];
            default:  step = 1'b0;
        endcase
    end

    tick_divider #(
        .PRE_W (6),
        .SCL_W (SCL_W)
    ) u_div (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_step     (step),
        .i_pre_sel  (ts_r[`TS_PRE_HI:`TS_PRE_LO]),
        .i_scale    (ts_r[`TS_SCL_HI:`TS_SCL_LO]),
        .o_tick     (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // counter: period mode wraps at the bound, pwm mode at 255 or 63
    assign pwm_mode = tc_r[`TC_PWM]; // RQ17
    assign cnt_top  = !pwm_mode ? bound_r :
                      (ts_r[`TS_6BIT] ? `PWM6_TOP : `PWM8_TOP); // RQ19
    assign cnt_wrap = cnt_r >= cnt_top;

    // a software write to the count wins over a tick in the same cycle
    always_comb begin
        cnt_nxt     = cnt_r;
        tmr_out_nxt = tmr_out_r;
        irq_nxt     = tick & (cnt_r == bound_r); // RQ20
        if (cnt_wr) begin
            cnt_nxt = i_pwdata[7:0]; // RQ14
        end else if (tick) begin
            cnt_nxt = cnt_wrap ? 8'h00 : 8'(cnt_r + 1'b1); // RQ15
            if (!pwm_mode && cnt_wrap) begin
                tmr_out_nxt = ~tmr_out_r; // RQ18
            end
        end
        if (pwm_mode) begin
            tmr_out_nxt = cnt_nxt <= bound_nxt; // RQ20
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cnt_r       <= 8'h00;
            tmr_out_r   <= 1'b0;
            timer_irq_r <= 1'b0;
            src_prev_r  <= 4'h0;
        end else begin
            cnt_r       <= cnt_nxt;
            tmr_out_r   <= tmr_out_nxt;
            timer_irq_r <= irq_nxt;
            src_prev_r  <= src_now;
        end
    end

    // output pin select; the pin only carries the wave while selected
    assign out_sel           = out_sel_t'(tc_r[`TC_OUT_HI:`TC_OUT_LO]);
    assign o_port_a_bit3_out = tmr_out_r;
    assign o_port_a_bit3_oe  = out_sel == OUT_PA3; // RQ11
    assign o_port_a_bit4_out = tmr_out_r;
    assign o_port_a_bit4_oe  = out_sel == OUT_PA4; // RQ11
    assign o_timer_irq_req   = timer_irq_r; // RQ16

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_minus_bgap;
        @(posedge i_core_clk) disable iff (i_rst)
        (cc_r[`CC_MINUS_HI:`CC_MINUS_LO] == MIN_BGAP) |-> (o_minus_route == 6'h04);
    endproperty
    a_minus_bgap: assert property (p_minus_bgap) // RQ1
        else $error("bandgap not routed to minus input");

    property p_invert;
        @(posedge i_core_clk) disable iff (i_rst)
        (cc_r[`CC_EN] && cc_r[`CC_INVERT]) |-> (comp_val == !i_comp_raw);
    endproperty
    a_invert: assert property (p_invert) // RQ3
        else $error("inverted result does not follow raw comparator");

    property p_sample;
        @(posedge i_core_clk) disable iff (i_rst)
        tick |=> (comp_samp_r == $past(comp_val));
    endproperty
    a_sample: assert property (p_sample) // RQ21
        else $error("sampled result not taken on tick");

    property p_pin_direct;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_port_a_bit0_oe && !cc_r[`CC_SAMPLED]) |=> (o_port_a_bit0_out == $past(comp_val));
    endproperty
    a_pin_direct: assert property (p_pin_direct) // RQ4
        else $error("pin does not carry the direct comparator result");

    property p_wrap;
        @(posedge i_core_clk) disable iff (i_rst)
        (tick && !pwm_mode && cnt_r == bound_r && !cnt_wr) |=> (cnt_r == 8'h00);
    endproperty
    a_wrap: assert property (p_wrap) // RQ15
        else $error("counter did not clear at the bound");

    property p_count_up;
        @(posedge i_core_clk) disable iff (i_rst)
        (tick && !cnt_wrap && !cnt_wr) |=> (cnt_r == 8'($past(cnt_r) + 1'b1));
    endproperty
    a_count_up: assert property (p_count_up) // RQ14
        else $error("counter did not step up by one");

    property p_toggle;
        @(posedge i_core_clk) disable iff (i_rst)
        (tick && !pwm_mode && cnt_wrap && !cnt_wr) |=> (tmr_out_r != $past(tmr_out_r));
    endproperty
    a_toggle: assert property (p_toggle) // RQ18
        else $error("period output did not toggle at wrap");

    property p_pwm_level;
        @(posedge i_core_clk) disable iff (i_rst)
        (pwm_mode && !bound_wr) |=> (tmr_out_r == (cnt_r <= bound_r));
    endproperty
    a_pwm_level: assert property (p_pwm_level) // RQ20
        else $error("pwm level disagrees with count and bound");

    property p_six_bit;
        @(posedge i_core_clk) disable iff (i_rst)
        (tick && pwm_mode && ts_r[`TS_6BIT] && cnt_r == `PWM6_TOP && !cnt_wr) |=> (cnt_r == 8'h00);
    endproperty
    a_six_bit: assert property (p_six_bit) // RQ19
        else $error("six-bit pwm did not wrap after 64 ticks");

endmodule : cmp_pwm_timer

`default_nettype wire

// [rtl/cmp_pwm_defines.svh]
// register offsets, field positions and reset values of the comparator and pwm timer
`ifndef CMP_PWM_DEFINES_SVH
`define CMP_PWM_DEFINES_SVH

// byte addresses on the register bus
`define OFF_CMP_CTRL    8'h00
`define OFF_REF_SEL     8'h04
`define OFF_TMR_CTRL    8'h08
`define OFF_TMR_SCALER  8'h0C
`define OFF_TMR_COUNT   8'h10
`define OFF_TMR_BOUND   8'h14

// reset value of every register
`define REG_RST         8'h00

// comparator_control fields
`define CC_EN           7
`define CC_RESULT       6
`define CC_SAMPLED      5
`define CC_INVERT       4
`define CC_MINUS_HI     3
`define CC_MINUS_LO     1
`define CC_PLUS         0

// reference_select fields
`define RS_PIN_OUT      7
`define RS_RANGE_HI     5
`define RS_RANGE_LO     4
`define RS_TAP_HI       3
`define RS_TAP_LO       0

// timer_control fields
`define TC_SRC_HI       7
`define TC_SRC_LO       4
`define TC_OUT_HI       3
`define TC_OUT_LO       2
`define TC_PWM          1

// timer_scaler fields
`define TS_6BIT         7
`define TS_PRE_HI       6
`define TS_PRE_LO       5
`define TS_SCL_HI       4
`define TS_SCL_LO       0

// counter tops in pwm mode
`define PWM8_TOP        8'hFF
`define PWM6_TOP        8'h3F

// prescaler terminal counts for divide by 1, 4, 16, 64
`define PRE_TOP_1       6'h00
`define PRE_TOP_4       6'h03
`define PRE_TOP_16      6'h0F
`define PRE_TOP_64      6'h3F

`endif

// [rtl/cmp_pwm_pkg.sv]
// types shared by the comparator and pwm timer
package cmp_pwm_pkg;

    // timer clock source codes
    typedef enum logic [3:0] {
        SRC_STOP = 4'b0000,
        SRC_SYS  = 4'b0001,
        SRC_FAST = 4'b0010,
        SRC_SLOW = 4'b0100,
        SRC_PA0  = 4'b1000,
        SRC_PA4  = 4'b1010
    } tm_src_t;

    // timer output pin codes
    typedef enum logic [1:0] {
        OUT_OFF  = 2'b00,
        OUT_OFF2 = 2'b01,
        OUT_PA3  = 2'b10,
        OUT_PA4  = 2'b11
    } out_sel_t;

    // comparator minus input codes
    typedef enum logic [2:0] {
        MIN_PA3  = 3'b000,
        MIN_PA4  = 3'b001,
        MIN_BGAP = 3'b010,
        MIN_LADR = 3'b011,
        MIN_PA6  = 3'b100,
        MIN_PA7  = 3'b101
    } minus_sel_t;

endpackage : cmp_pwm_pkg

// [rtl/tick_divider.sv]
// prescaler and scaler that turn source steps into timer ticks
`timescale 1ns/1ps
`default_nettype none
`include "cmp_pwm_defines.svh"

module tick_divider
    import cmp_pwm_pkg::*;
#(
    parameter int PRE_W = 6,
    parameter int SCL_W = 5
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic             i_step,
    input  wire logic [1:0]       i_pre_sel,
    input  wire logic [SCL_W-1:0] i_scale,
    output logic                  o_tick
);

    logic [PRE_W-1:0] pre_cnt_r;
    logic [PRE_W-1:0] pre_cnt_nxt;
    logic [SCL_W-1:0] scl_cnt_r;
    logic [SCL_W-1:0] scl_cnt_nxt;
    logic [PRE_W-1:0] pre_top;
    logic             pre_wrap;
    logic             scl_wrap;

    ////////////////////////////////////////////////////////////////////////
    // the prescaler counts source steps, the scaler counts prescaler wraps; >= guards against a smaller new top
    always_comb begin
        case (i_pre_sel)
            2'b00:   pre_top = `PRE_TOP_1;
            2'b01:   pre_top = `PRE_TOP_4;
            2'b10:   pre_top = `PRE_TOP_16;
            default: pre_top = `PRE_TOP_64;
        endcase
        pre_wrap    = pre_cnt_r >= pre_top;
        scl_wrap    = scl_cnt_r >= i_scale;
        pre_cnt_nxt = pre_cnt_r;
        scl_cnt_nxt = scl_cnt_r;
        o_tick      = i_step & pre_wrap & scl_wrap; // RQ13
        if (i_step) begin
            pre_cnt_nxt = pre_wrap ? '0 : PRE_W'(pre_cnt_r + 1'b1); // RQ12
            if (pre_wrap) begin
                scl_cnt_nxt = scl_wrap ? '0 : SCL_W'(scl_cnt_r + 1'b1); // RQ13
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pre_cnt_r <= '0;
            scl_cnt_r <= '0;
        end else begin
            pre_cnt_r <= pre_cnt_nxt;
            scl_cnt_r <= scl_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a tick with divide by 1 on both stages follows every step at once
    property p_tick_step;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_step && i_pre_sel == 2'b00 && i_scale == '0) |-> o_tick;
    endproperty
    a_tick_step: assert property (p_tick_step) // RQ12
        else $error("tick missing with both dividers at one");

endmodule : tick_divider

`default_nettype wire

// [verif/pin_side_model.sv]
// far side model: analog comparator decision and the external clock pins
`timescale 1ns/1ps
`default_nettype none

module pin_side_model (
    input  wire logic i_core_clk,
    input  wire logic i_raw_level,
    output logic      o_comp_raw,
    output logic      o_fast_rc_osc,
    output logic      o_slow_rc_osc,
    output logic      o_port_a_bit0,
    output logic      o_port_a_bit4
);
    int n = 0;

    // free-running counter, so every source below has a fixed rising-edge spacing
    always_ff @(posedge i_core_clk) begin
        n <= n + 1;
    end

    // distinct rates, so a wrong source pick changes the measured period
    assign o_fast_rc_osc = n[1];            // rises every 4 cycles
    assign o_slow_rc_osc = n[3];            // rises every 16 cycles
    assign o_port_a_bit0 = (n % 6) < 3;     // rises every 6 cycles
    assign o_port_a_bit4 = (n % 10) < 5;    // rises every 10 cycles
    // analog pins reach the block as the comparator decision, except pa4, which also drives the digital timer source input
    assign o_comp_raw = i_raw_level;
endmodule : pin_side_model

`default_nettype wire

// [verif/comparator_and_pwm_timer_tb.sv]
// self-checking bench for the comparator and pwm timer block
`timescale 1ns/1ps
`default_nettype none

module comparator_and_pwm_timer_tb
    import cmp_pwm_pkg::*;
;
    logic        core_clk, rst, psel, penable, pwrite, raw;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, e, comp_raw, fast, slow, pa0, pa4;
    logic        comp_en, plus_pa4, plus_ladr, cirq, tirq;
    logic [5:0]  minus_rt;
    logic [1:0]  lrange;
    logic [3:0]  ltap;
    logic        pa0_out, pa0_oe, pa3_out, pa3_oe, pa4_out, pa4_oe;
    int          bad_count = 0;
    int          checks_done = 0;
    int          shadow [6];
    tm_src_t     srcs [5] = '{SRC_SYS, SRC_FAST, SRC_SLOW, SRC_PA0, SRC_PA4};
    int          rate [5] = '{1, 4, 16, 6, 10};

    cmp_pwm_timer u_cmp_pwm_timer (
        .i_core_clk(core_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_prdata(prdata), .i_comp_raw(comp_raw),
        .i_fast_rc_osc(fast), .i_slow_rc_osc(slow), .i_port_a_bit0(pa0),
        .i_port_a_bit4(pa4), .o_comp_enable(comp_en), .o_minus_route(minus_rt),
        .o_plus_port_a_bit4(plus_pa4), .o_plus_ladder(plus_ladr),
        .o_ladder_range(lrange), .o_ladder_tap(ltap), .o_comp_irq_req(cirq),
        .o_timer_irq_req(tirq), .o_port_a_bit0_out(pa0_out), .o_port_a_bit0_oe(pa0_oe),
        .o_port_a_bit3_out(pa3_out), .o_port_a_bit3_oe(pa3_oe),
        .o_port_a_bit4_out(pa4_out), .o_port_a_bit4_oe(pa4_oe));

    pin_side_model u_pin_side_model (
        .i_core_clk(core_clk), .i_raw_level(raw), .o_comp_raw(comp_raw),
        .o_fast_rc_osc(fast), .o_slow_rc_osc(slow), .o_port_a_bit0(pa0),
        .o_port_a_bit4(pa4));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer held until pready; ends at a falling edge so outputs have settled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && a < 8'h18) shadow[a[4:2]] = (a == 8'h00) ? d & 32'hBF : d & 32'hFF;
        @(negedge core_clk);
    endtask : apb

    // read compared with the shadow; the live result bit is masked out
    task automatic rd_chk(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        chk("read data", (a == 8'h00) ? q & 32'hFFFFFFBF : q, shadow[a[4:2]]);
    endtask : rd_chk

    // one full high and low phase of the pa3 wave, counting timer requests
    task automatic measure(output int hi, output int lo, output int ir);
        hi = 0;
        lo = 0;
        ir = 0;
        while (pa3_out !== 1'b0) @(posedge core_clk);
        while (pa3_out !== 1'b1) @(posedge core_clk);
        while (pa3_out === 1'b1) begin
            hi++;
            ir += tirq;
            @(posedge core_clk);
        end
        while (pa3_out === 1'b0) begin
            lo++;
            ir += tirq;
            @(posedge core_clk);
        end
    endtask : measure

    task automatic give_verdict();
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // watchdog well beyond the longest expected run
    initial begin
        repeat (90000) @(posedge core_clk);
        bad_count++;
        give_verdict();
    end

    initial begin
        int hi, lo, ir, k, pc, sc;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        raw = 1'b0;
        shadow = '{0, 0, 0, 0, 0, 0};
        q = $urandom(16201);
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(8'(i * 4));
        chk("minus route", minus_rt, 32'h01);
        chk("plus ladder", plus_ladr, 32'h1);
        // unmapped place: flagged, write lost, reads zero
        apb(1'b1, 8'h18, 32'hFF);
        chk("unmapped error", e, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped read", q, 32'h0);
        // random contents with the timer stopped, so the count stays put
        for (int i = 1; i < 6; i++) begin
            if (i != 2) begin
                apb(1'b1, 8'(i * 4), $urandom());
                rd_chk(8'(i * 4));
            end
        end
        chk("ladder range", lrange, shadow[1][5:4]);
        chk("ladder tap", ltap, shadow[1] & 15);
        // every minus source against both plus sources
        for (int c = 0; c < 8; c++) begin
            for (int p = 0; p < 2; p++) begin
                apb(1'b1, 8'h00, 32'h80 | (c << 1) | p);
                chk("minus route", minus_rt, (c < 6) ? 32'h1 << c : 32'h0);
                chk("plus pin", plus_pa4, p);
                chk("plus ladder", plus_ladr, 1 - p);
                chk("enable", comp_en, 32'h1);
            end
        end
        // result rises once per polarity: request, direct pin and status bit follow
        apb(1'b1, 8'h04, 32'h80);
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, 8'h00, 32'h80 | (inv << 4));
            @(posedge core_clk);
            raw <= inv[0];
            repeat (3) @(posedge core_clk);
            raw <= ~inv[0];
            ir = 0;
            repeat (4) begin
                @(posedge core_clk);
                ir += cirq;
            end
            chk("comparator request", ir, 1);
            chk("pa0 drive", pa0_oe, 1);
            chk("pa0 level", pa0_out, 1);
            apb(1'b0, 8'h00, 32'h0);
            chk("result status", q[6], 1);
        end
        // period mode from every source; count cleared first so each run counts up from zero
        for (int s = 0; s < 5; s++) begin
            k = $urandom_range(7, 1);
            pc = $urandom_range(1, 0);
            sc = $urandom_range(3, 0);
            apb(1'b1, 8'h08, 32'h0);
            chk("pins undriven", pa3_oe | pa4_oe, 0);
            apb(1'b1, 8'h10, 32'h0);
            apb(1'b1, 8'h14, k);
            apb(1'b1, 8'h0C, (pc << 5) | sc);
            apb(1'b1, 8'h08, {srcs[s], 4'b1000});
            chk("pa3 drive", pa3_oe, 1);
            measure(hi, lo, ir);
            k = (k + 1) * rate[s] * (1 << (2 * pc)) * (sc + 1);
            chk("period high", hi, k);
            chk("period low", lo, k);
            chk("period requests", ir, 2);
        end
        // pwm at 8 and 6 bit resolution on the system clock
        for (int r = 0; r < 2; r++) begin
            k = $urandom_range(30, 0);
            apb(1'b1, 8'h14, k);
            apb(1'b1, 8'h0C, r << 7);
            apb(1'b1, 8'h08, 32'h1A);
            measure(hi, lo, ir);
            chk("pwm high", hi, k + 1);
            chk("pwm low", lo, (r ? 63 : 255) - k);
            chk("pwm requests", ir, 1);
        end
        // output moved to pa4, timer stopped, count loaded by software
        apb(1'b1, 8'h08, 32'h0C);
        chk("pa4 drive", pa4_oe, 1);
        chk("pa3 drive", pa3_oe, 0);
        apb(1'b1, 8'h10, $urandom());
        rd_chk(8'h10);
        // pwm level follows count and bound even while stopped
        apb(1'b1, 8'h08, 32'h0E);
        apb(1'b1, 8'h14, $urandom());
        chk("pa4 level", pa4_out, shadow[4] <= shadow[5]);
        // pin keeps the last ticked result (inverted low raw) until ticks resume
        apb(1'b1, 8'h00, 32'hA0);
        repeat (2) @(negedge core_clk);
        chk("pa0 sampled", pa0_out, 1);
        apb(1'b1, 8'h08, 32'h1E);
        repeat (3) @(negedge core_clk);
        chk("pa0 sampled", pa0_out, 0);
        give_verdict();
    end
endmodule : comparator_and_pwm_timer_tb

`default_nettype wire
